// ==== rtl/usb_ls_pkg.sv ====
// Package with the register map, field layouts and types of the low-speed function registers.
package usb_ls_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_DMA_HIGH   = 4'h0;
  localparam logic [3:0] ADDR_DMA_LOW    = 4'h1;
  localparam logic [3:0] ADDR_TOKEN      = 4'h2;
  localparam logic [3:0] ADDR_FLAGS      = 4'h3;
  localparam logic [3:0] ADDR_ENABLES    = 4'h4;
  localparam logic [3:0] ADDR_POWER      = 4'h5;
  localparam logic [3:0] ADDR_HOST_ID    = 4'h6;
  localparam logic [3:0] ADDR_EP0_TX     = 4'h7;
  localparam logic [3:0] ADDR_EP1_TX     = 4'h8;
  localparam logic [3:0] ADDR_EP2_TX     = 4'h9;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned FLAG_DMA_LATE  = 6;
  localparam int unsigned FLAG_GOOD      = 5;
  localparam int unsigned FLAG_FAULT     = 4;
  localparam int unsigned FLAG_OVERRUN   = 3;
  localparam int unsigned FLAG_WAKE      = 2;
  localparam int unsigned FLAG_BUS_RESET = 1;
  localparam int unsigned FLAG_SOF       = 0;
  localparam int unsigned NUM_FLAGS      = 7;
  localparam int unsigned NUM_EP         = 3;

  localparam logic [6:0] FLAGS_RESET     = 7'h00;
  localparam logic [6:0] ENABLES_RESET   = 7'h00;
  localparam logic [3:0] POWER_RESET     = 4'h6;
  localparam logic [6:0] HOST_ID_RESET   = 7'h00;
  localparam logic [9:0] DMA_BASE_RESET  = 10'h000;
  localparam logic [1:0] TOKEN_PID_LOW   = 2'h1;
  localparam logic [5:0] TOKEN_PAD       = 6'h00;
  localparam logic [0:0] ZERO_BIT        = 1'h0;
  localparam logic [2:0] ZERO_3          = 3'h0;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  localparam logic [6:0] ALL_KEEP        = 7'h7F;

  localparam int unsigned PWR_RESUME     = 3;
  localparam int unsigned PWR_REG_OFF    = 2;
  localparam int unsigned PWR_LOW_POWER  = 1;
  localparam int unsigned PWR_FORCE_INIT = 0;

  // Token kinds as seen in PID bits 3:2.
  localparam logic [1:0] TOKEN_OUT       = 2'h0;
  localparam logic [1:0] TOKEN_IN        = 2'h2;
  localparam logic [1:0] TOKEN_SETUP     = 2'h3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 25000;
  localparam int unsigned REG_SETTLE_US  = 3;
  localparam int unsigned REG_SETTLE_CYC =
    (REG_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_DISABLED = 2'h0,
    TX_STALL    = 2'h1,
    TX_NAK      = 2'h2,
    TX_VALID    = 2'h3
  } tx_state_t;

  typedef struct packed {
    logic      status_stage_expect;
    logic      tx_toggle_bit;
    tx_state_t state;
    logic [3:0] tx_length;
  } ep_tx_t;

  localparam ep_tx_t EP_TX_RESET = '{1'b0, 1'b0, TX_DISABLED, 4'h0};

  typedef struct packed {
    logic       done;
    logic       ok;
    logic       answered_nak_stall;
    logic       is_rx;
    logic [1:0] endpoint_id;
    logic [1:0] token_kind_bits;
    logic [3:0] rx_byte_count;
  } xfer_t;

  typedef struct packed {
    logic timeout;
    logic crc;
    logic stuffing;
    logic framing;
  } bus_err_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] endpoint_id;
    logic       is_tx;
    logic [2:0] byte_index;
  } dma_req_t;

endpackage

// ==== rtl/usb_ls_regs.sv ====
// Register, event and endpoint transmit control logic of the low-speed USB function.
//
// Behaviour
// R1: Software gives DMA base bits 15:6; bits 7:6 sit in the low register.
// R2: Endpoint identifier reads 00, 01 or 10 for endpoints zero, one, two.
// R3: Four-bit receive count holds bytes of last reception; meaningless after transmit.
// R4: Token register holds PID bits 3:2 on top, zeros below, low bits implied 01.
// R5: Token kind codes: 00 OUT, 10 IN, 11 SETUP.
// R6: Only hardware sets event flags; software only clears them; reset to zero.
// R7: DMA-late flag bit 6 set on any DMA overrun or underrun.
// R8: Good-transfer flag bit 5 set only on error-free transfers not NAKed or STALLed.
// R9: Bus-fault flag bit 4 set on timeout, CRC, stuffing or framing error.
// R10: Flag-overrun bit 3 set when fault, wake or frame flag is set again.
// R11: Wake-detect bit 2 set on bus activity during suspend; own interrupt line.
// R12: Bus-reset flag bit 1 set on bus reset, which clears address and endpoints.
// R13: Start-of-frame bit 0 set on each keep-alive strobe.
// R14: Interrupt when flag and mask both set and CPU interrupt-disable is clear.
// R15: Writing 0 clears a flag, writing 1 leaves it unchanged.
// R16: Resume bit 3 drives resume signalling while suspended; software clears it.
// R17: Regulator-off bit 2 powers down regulator; 3 us settling; resets to 1.
// R18: Low-power bit 1 enters suspend; hardware clears it on bus activity; resets 1.
// R19: Force-init bit 0 holds bus-reset state; clearing it raises bus-reset event.
// R20: Address register holds seven-bit identifier, bit 7 zero, cleared by resets.
// R21: Status-stage-expect bit 7 makes nonzero OUT data get STALL, not ACK.
// R22: Transmit toggle picks DATA0/DATA1; set on SETUP, flipped on ACK, writable.
// R23: Transmit state 00 off, 01 STALL, 10 NAK, 11 valid; NAK after good IN/SETUP.
// R24: Software writes transmit length 0 to 8 into four-bit field.
// R25: Each DMA slot fills upward from byte offset 000.
// R26: Slots ascend: EP0 RX, EP0 TX, EP1 RX, EP1 TX, EP2 RX, EP2 TX.
// R27: Overrun, wake and DMA-late flags stay set until software clears them.
`timescale 1ns/10ps
module usb_ls_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  input  wire usb_ls_pkg::xfer_t    xfer,
  input  wire usb_ls_pkg::bus_err_t bus_err,
  input  wire logic                 dma_late,
  input  wire logic                 bus_activity,
  input  wire logic                 bus_reset_seen,
  input  wire logic                 keep_alive,
  input  wire logic                 setup_seen,
  input  wire logic                 host_ack,
  input  wire logic [1:0]           pid_ep,
  input  wire logic                 out_nonzero,
  input  wire usb_ls_pkg::dma_req_t dma_req,
  input  wire logic                 cpu_irq_disable,
  output logic                      irq_req,
  output logic                      wake_irq_req,
  output logic [15:0]               dma_addr,
  output logic                      dma_addr_valid,
  output usb_ls_pkg::ep_tx_t        ep_view,
  output logic                      out_stall,
  output logic                      resume_drive,
  output logic                      regulator_off,
  output logic                      regulator_ready,
  output logic                      low_power,
  output logic                      sie_hold_reset,
  output logic [6:0]                host_id
);
  import usb_ls_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0]           dma_high_reg;
  logic [1:0]           dma_base_low_bits_reg;
  logic [1:0]           endpoint_id_reg;
  logic [3:0]           rx_byte_count_reg;
  logic [1:0]           token_kind_bits_reg;
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] flags_next;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] enables_reg;
  logic [3:0]           power_reg;
  logic [6:0]           host_id_reg;
  ep_tx_t               ep_reg [NUM_EP];
  logic [7:0]           settle_cnt_reg;
  logic                 usb_reset;
  logic                 good_xfer;
  logic                 force_release;
  logic [6:0]           clear_keep;

  function automatic logic hit(input logic [3:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // Slot index of an endpoint buffer, receive slot first.
  function automatic logic [2:0] slot_of(input logic [1:0] ep, input logic is_tx);
    return {ep, is_tx};
  endfunction

  // A forced reset acts like a reset coming from the bus, but raises the bus-reset flag only when it is released.
  assign usb_reset     = bus_reset_seen || power_reg[PWR_FORCE_INIT];                // [R19]
  assign force_release = hit(ADDR_POWER) && power_reg[PWR_FORCE_INIT]
                         && !reg_wdata[PWR_FORCE_INIT];                              // [R19]
  assign good_xfer     = xfer.done && xfer.ok && !xfer.answered_nak_stall;           // [R8]

  // ---------------------------------------------------------------------------
  // DMA base and transfer identification
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dma_high_reg          <= DMA_BASE_RESET[9:2];
      dma_base_low_bits_reg <= DMA_BASE_RESET[1:0];
    end else begin
      if (hit(ADDR_DMA_HIGH)) begin
        dma_high_reg <= reg_wdata;                                                   // [R1]
      end
      if (hit(ADDR_DMA_LOW)) begin
        dma_base_low_bits_reg <= reg_wdata[7:6];                                     // [R1]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      endpoint_id_reg     <= 2'h0;
      rx_byte_count_reg   <= 4'h0;
      token_kind_bits_reg <= TOKEN_OUT;
    end else if (good_xfer) begin
      endpoint_id_reg     <= xfer.endpoint_id;                                       // [R2]
      token_kind_bits_reg <= xfer.token_kind_bits;                                   // [R4] [R5]
      if (xfer.is_rx) begin
        rx_byte_count_reg <= xfer.rx_byte_count;                                     // [R3]
      end
    end
  end

  // Low address bits come from the slot and byte position, so buffers stay aligned.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dma_addr       <= 16'h0000;
      dma_addr_valid <= 1'b0;
    end else begin
      dma_addr_valid <= dma_req.valid;
      dma_addr       <= {dma_high_reg, dma_base_low_bits_reg,
                         slot_of(dma_req.endpoint_id, dma_req.is_tx),                // [R26]
                         dma_req.byte_index};                                        // [R25]
    end
  end

  // ---------------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------------
  always_comb begin
    flag_set                 = '0;
    flag_set[FLAG_DMA_LATE]  = dma_late;                                             // [R7]
    flag_set[FLAG_GOOD]      = good_xfer;                                            // [R8]
    flag_set[FLAG_FAULT]     = |bus_err;                                             // [R9]
    flag_set[FLAG_WAKE]      = bus_activity && power_reg[PWR_LOW_POWER];             // [R11]
    flag_set[FLAG_BUS_RESET] = bus_reset_seen || force_release;                      // [R12] [R19]
    flag_set[FLAG_SOF]       = keep_alive;                                           // [R13]
    flag_set[FLAG_OVERRUN]   = (flag_set[FLAG_FAULT] && flags_reg[FLAG_FAULT])
                             || (flag_set[FLAG_WAKE] && flags_reg[FLAG_WAKE])
                             || (flag_set[FLAG_SOF] && flags_reg[FLAG_SOF]);         // [R10]
    clear_keep = hit(ADDR_FLAGS) ? reg_wdata[6:0] : ALL_KEEP;                        // [R15]
    // A new event in the clearing cycle survives the clear.
    flags_next = (flags_reg & clear_keep) | flag_set;                                // [R6] [R27]
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags_reg <= FLAGS_RESET;                                                      // [R6]
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      enables_reg <= ENABLES_RESET;
    end else if (hit(ADDR_ENABLES)) begin
      enables_reg <= reg_wdata[6:0];
    end
  end

  assign irq_req      = |(flags_reg & enables_reg) && !cpu_irq_disable;              // [R14]
  assign wake_irq_req = flags_reg[FLAG_WAKE] && enables_reg[FLAG_WAKE]
                        && !cpu_irq_disable;                                         // [R11]

  // ---------------------------------------------------------------------------
  // Power control
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      power_reg <= POWER_RESET;                                                      // [R17] [R18]
    end else begin
      if (hit(ADDR_POWER)) begin
        power_reg <= reg_wdata[3:0];                                                 // [R16] [R19]
      end
      // Bus activity wakes the function even if software just asked to sleep.
      if (bus_activity) begin
        power_reg[PWR_LOW_POWER] <= 1'b0;                                            // [R18]
      end
    end
  end

  // Counts the settling time after the regulator is turned back on.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      settle_cnt_reg <= 8'h00;
    end else if (power_reg[PWR_REG_OFF]) begin
      settle_cnt_reg <= 8'h00;
    end else if (settle_cnt_reg != REG_SETTLE_CYC[7:0]) begin
      settle_cnt_reg <= settle_cnt_reg + 8'h01;                                      // [R17]
    end
  end

  assign regulator_off   = power_reg[PWR_REG_OFF];                                   // [R17]
  assign regulator_ready = settle_cnt_reg == REG_SETTLE_CYC[7:0];
  assign low_power       = power_reg[PWR_LOW_POWER];
  assign resume_drive    = power_reg[PWR_RESUME] && power_reg[PWR_LOW_POWER];        // [R16]
  assign sie_hold_reset  = usb_reset;                                                // [R19]

  // ---------------------------------------------------------------------------
  // Address and endpoint transmit control
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst || usb_reset) begin
      host_id_reg <= HOST_ID_RESET;                                                  // [R20] [R12]
    end else if (hit(ADDR_HOST_ID)) begin
      host_id_reg <= reg_wdata[6:0];                                                 // [R20]
    end
  end
  assign host_id = host_id_reg;

  // Software writes land first so that hardware updates of the same cycle win.
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NUM_EP; i++) begin
      if (!nrst || usb_reset) begin
        ep_reg[i] <= EP_TX_RESET;                                                    // [R12]
      end else begin
        if (hit(ADDR_EP0_TX + 4'(i))) begin
          ep_reg[i] <= ep_tx_t'(reg_wdata);                                          // [R24] [R22]
        end
        if (setup_seen && pid_ep == 2'(i)) begin
          ep_reg[i].tx_toggle_bit <= 1'b1;                                           // [R22]
        end else if (host_ack && pid_ep == 2'(i)) begin
          ep_reg[i].tx_toggle_bit <= !ep_reg[i].tx_toggle_bit;                       // [R22]
        end
        if (good_xfer && xfer.endpoint_id == 2'(i)
            && xfer.token_kind_bits != TOKEN_OUT) begin
          ep_reg[i].state <= TX_NAK;                                                 // [R23]
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ep_view <= EP_TX_RESET;
    end else begin
      ep_view <= (pid_ep < 2'(NUM_EP)) ? ep_reg[pid_ep] : EP_TX_RESET;
    end
  end

  // Handshake decision for the current OUT data phase.
  assign out_stall = (pid_ep < 2'(NUM_EP)) && out_nonzero
                     && ep_reg[pid_ep].status_stage_expect;                          // [R21]

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_DMA_HIGH) begin
        reg_rdata <= dma_high_reg;
      end else if (reg_addr == ADDR_DMA_LOW) begin
        reg_rdata <= {dma_base_low_bits_reg, endpoint_id_reg, rx_byte_count_reg};    // [R2] [R3]
      end else if (reg_addr == ADDR_TOKEN) begin
        reg_rdata <= {token_kind_bits_reg, TOKEN_PAD};                               // [R4]
      end else if (reg_addr == ADDR_FLAGS) begin
        reg_rdata <= {ZERO_BIT, flags_reg};
      end else if (reg_addr == ADDR_ENABLES) begin
        reg_rdata <= {ZERO_BIT, enables_reg};
      end else if (reg_addr == ADDR_POWER) begin
        reg_rdata <= {4'h0, power_reg};
      end else if (reg_addr == ADDR_HOST_ID) begin
        reg_rdata <= {ZERO_BIT, host_id_reg};                                        // [R20]
      end else if (reg_addr >= ADDR_EP0_TX && reg_addr <= ADDR_EP2_TX) begin
        reg_rdata <= ep_reg[2'(reg_addr - ADDR_EP0_TX)];
      end else begin
        reg_rdata <= READ_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  flag_no_sw_set_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (flag_set == '0) |=> ((flags_reg & ~$past(flags_reg)) == '0))                   // [R6]
    else $error("event flag rose with no hardware event");

  flag_clear_zero_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (hit(ADDR_FLAGS) && !reg_wdata[FLAG_SOF] && !keep_alive) |=> !flags_reg[FLAG_SOF]) // [R15]
    else $error("frame flag not cleared by a zero write");

  good_flag_set_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (xfer.done && xfer.ok && !xfer.answered_nak_stall) |=> flags_reg[FLAG_GOOD]) // [R8]
    else $error("good transfer did not raise its flag");

  nak_no_good_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (!flags_reg[FLAG_GOOD] && xfer.answered_nak_stall) |=> !flags_reg[FLAG_GOOD]) // [R8]
    else $error("refused transfer raised the good flag");

  overrun_set_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (keep_alive && flags_reg[FLAG_SOF]) |=> flags_reg[FLAG_OVERRUN])               // [R10]
    else $error("repeat frame strobe did not raise overrun");

  irq_gate_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    irq_req == ((|(flags_reg & enables_reg)) && !cpu_irq_disable))                  // [R14]
    else $error("interrupt request disagrees with flags and masks");

  reset_clears_id_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_reset_seen |=> (host_id == 7'h00 && ep_reg[0] == EP_TX_RESET))              // [R12]
    else $error("bus reset left address or endpoint state");

  release_event_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    force_release |=> (flags_reg[FLAG_BUS_RESET] && !sie_hold_reset) ##1 !sie_hold_reset) // [R19]
    else $error("leaving forced reset did not raise the reset event");

  wake_clears_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (bus_activity && low_power) |=> (!low_power && flags_reg[FLAG_WAKE]))          // [R18]
    else $error("bus activity did not end suspend");

  nak_after_in_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (good_xfer && xfer.endpoint_id == 2'h1 && xfer.token_kind_bits == TOKEN_IN
     && !usb_reset) |=> ep_reg[1].state == TX_NAK)                                  // [R23]
    else $error("endpoint not forced to NAK after good IN");

  stall_out_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (pid_ep == 2'h0 && out_nonzero && !ep_reg[0].status_stage_expect) |-> !out_stall) // [R21]
    else $error("OUT data stalled without status expectation");

  toggle_on_setup_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (setup_seen && pid_ep == 2'h1 && !usb_reset) |=> ep_reg[1].tx_toggle_bit)       // [R22]
    else $error("SETUP did not select DATA1 for the next packet");

  settle_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(regulator_off) |-> !regulator_ready[*8])                                  // [R17]
    else $error("regulator reported ready too early");

endmodule

// ==== test/host_side.sv ====
// Host-side stand-in that turns bench commands into one-cycle bus event pulses.
`timescale 1ns/10ps
module host_side (
  input  wire logic            ref_clk,
  input  wire logic [2:0]      cmd,
  output logic                 keep_alive,
  output logic                 bus_activity,
  output logic                 dma_late,
  output logic                 bus_reset_seen,
  output usb_ls_pkg::bus_err_t bus_err
);
  import usb_ls_pkg::*;
  // Fault kinds rotate, so four faults in a row exercise every error source.
  logic [1:0] kind_reg = 2'h0;
  always @(posedge ref_clk) begin
    if (cmd == 3'h5) kind_reg <= kind_reg + 2'h1;
  end
  assign keep_alive     = (cmd == 3'h1);
  assign bus_activity   = (cmd == 3'h2);
  assign dma_late       = (cmd == 3'h3);
  assign bus_reset_seen = (cmd == 3'h4);
  assign bus_err = (cmd == 3'h5) ? bus_err_t'(4'h1 << kind_reg) : bus_err_t'(4'h0);
endmodule

// ==== test/usb_ls_regs_tb.sv ====
// Self-checking bench for the low-speed function registers against a queue-free integer model.
`timescale 1ns/10ps
module usb_ls_regs_tb;
  import usb_ls_pkg::*;
  logic        ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, setup_seen = 1'b0;
  logic        host_ack = 1'b0, out_nonzero = 1'b0, cpu_irq_disable = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rv;
  logic [2:0]  cmd = 3'h0;
  logic [1:0]  pid_ep = 2'h0;
  xfer_t       xfer = '0;
  dma_req_t    dma_req = '0;
  bus_err_t    bus_err;
  logic        keep_alive, bus_activity, dma_late, bus_reset_seen, irq_req, wake_irq_req, out_stall;
  logic [15:0] dma_addr;
  logic        dma_addr_valid, resume_drive, regulator_off;
  logic        regulator_ready, low_power, sie_hold_reset;
  logic [6:0]  host_id;
  ep_tx_t      ep_view;
  int n_mismatch = 0, cmp_count = 0, flags = 0, ep, cnt, hi, lo, last_cnt = 0;
  int          bitn[6] = '{0, 0, 2, 6, 1, 4};
  int          seq[8] = '{1, 1, 2, 3, 5, 5, 5, 5};
  logic [1:0]  kinds[3] = '{TOKEN_OUT, TOKEN_IN, TOKEN_SETUP};
  usb_ls_regs usb_ls_regs_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer(xfer),
    .bus_err(bus_err), .dma_late(dma_late), .bus_activity(bus_activity),
    .bus_reset_seen(bus_reset_seen), .keep_alive(keep_alive), .setup_seen(setup_seen),
    .host_ack(host_ack), .pid_ep(pid_ep), .out_nonzero(out_nonzero), .dma_req(dma_req),
    .cpu_irq_disable(cpu_irq_disable), .irq_req(irq_req), .wake_irq_req(wake_irq_req),
    .dma_addr(dma_addr), .dma_addr_valid(dma_addr_valid), .ep_view(ep_view),
    .out_stall(out_stall), .resume_drive(resume_drive), .regulator_off(regulator_off),
    .regulator_ready(regulator_ready), .low_power(low_power), .sie_hold_reset(sie_hold_reset),
    .host_id(host_id));
  host_side host_side_inst (.ref_clk(ref_clk), .cmd(cmd), .keep_alive(keep_alive),
    .bus_activity(bus_activity), .dma_late(dma_late), .bus_reset_seen(bus_reset_seen),
    .bus_err(bus_err));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // A pulse is followed by one idle cycle, so repeats land on separate edges.
  task automatic pulse(input int c);
    @(posedge ref_clk);
    cmd <= 3'(c);
    @(posedge ref_clk);
    cmd <= 3'h0;
    if (flags[bitn[c]] && bitn[c] inside {0, 2, 4}) flags |= 8;
    flags |= 1 << bitn[c];
  endtask
  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(48));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_POWER); chk(rv, 8'h06);
    chk({regulator_off, low_power}, 2'b11);
    wr(ADDR_FLAGS, 8'hFF); rd(ADDR_FLAGS); chk(rv, 8'h00);
    rd(4'hF); chk(rv, 8'h00);
    wr(ADDR_ENABLES, 8'h7F);
    for (int i = 0; i < 8; i++) begin
      pulse(seq[i]); rd(ADDR_FLAGS); chk(rv, 16'(flags));
      chk(irq_req, 1'b1);
    end
    chk(wake_irq_req, 1'b1);
    rd(ADDR_POWER); chk(rv, 8'h04);
    chk(low_power, 1'b0);
    @(posedge ref_clk) cpu_irq_disable <= 1'b1;
    #1 chk(irq_req, 1'b0);
    @(posedge ref_clk) cpu_irq_disable <= 1'b0;
    wr(ADDR_FLAGS, 8'h7E); flags &= 'h7E; rd(ADDR_FLAGS); chk(rv, 16'(flags));
    wr(ADDR_FLAGS, 8'h00); flags = 0; #1 chk(irq_req, 1'b0);
    @(posedge ref_clk) xfer <= '{1'b1, 1'b1, 1'b1, 1'b1, 2'h1, TOKEN_OUT, 4'h3};
    @(posedge ref_clk) xfer <= '0;
    rd(ADDR_FLAGS); chk(rv, 8'h00);
    for (int k = 0; k < 3; k++) begin
      ep = $urandom % 3; cnt = $urandom % 9;
      wr(4'(ADDR_EP0_TX + ep), 8'h35);
      @(posedge ref_clk) xfer <= '{1'b1, 1'b1, 1'b0, k != 1, 2'(ep), kinds[k], 4'(cnt)};
      @(posedge ref_clk) xfer <= '0;
      if (k != 1) last_cnt = cnt;
      rd(ADDR_TOKEN); chk(rv, {kinds[k], 6'h00});
      rd(ADDR_DMA_LOW); chk(rv[5:0], {2'(ep), 4'(last_cnt)});
      rd(4'(ADDR_EP0_TX + ep)); chk(rv, (k == 0) ? 8'h35 : 8'h25);
      rd(ADDR_FLAGS); chk(rv, 8'h20);
    end
    hi = $urandom % 256; lo = $urandom % 4;
    wr(ADDR_DMA_HIGH, 8'(hi)); wr(ADDR_DMA_LOW, {2'(lo), 6'h00});
    for (int s = 0; s < 6; s++) begin
      cnt = $urandom % 8;
      @(posedge ref_clk) dma_req <= '{1'b1, 2'(s / 2), s[0], 3'(cnt)};
      @(posedge ref_clk) dma_req <= '0;
      #1 chk(dma_addr, 16'(hi * 256 + lo * 64 + s * 8 + cnt));
      chk(dma_addr_valid, 1'b1);
    end
    wr(ADDR_FLAGS, 8'h00); flags = 0;
    cnt = $urandom % 256; wr(ADDR_HOST_ID, 8'(cnt)); rd(ADDR_HOST_ID); chk(rv, cnt % 128);
    chk(host_id, cnt % 128);
    pulse(4); rd(ADDR_HOST_ID); chk(rv, 8'h00);
    rd(ADDR_EP0_TX); chk(rv, 8'h00);
    rd(ADDR_FLAGS); chk(rv, 16'(flags));
    wr(ADDR_FLAGS, 8'h00); wr(ADDR_HOST_ID, 8'h11); wr(ADDR_POWER, 8'h01);
    #1 chk({regulator_off, regulator_ready}, 2'b00);
    rd(ADDR_HOST_ID); chk(rv, 8'h00);
    chk(sie_hold_reset, 1'b1);
    wr(ADDR_POWER, 8'h00); rd(ADDR_FLAGS); chk(rv, 8'h02);
    chk(sie_hold_reset, 1'b0);
    wr(ADDR_EP1_TX, 8'h80);
    @(posedge ref_clk) pid_ep <= 2'h1;
    out_nonzero <= 1'b1;
    #1 chk(out_stall, 1'b1);
    @(posedge ref_clk) out_nonzero <= 1'b0;
    setup_seen <= 1'b1;
    @(posedge ref_clk) setup_seen <= 1'b0;
    #1 chk(out_stall, 1'b0);
    rd(ADDR_EP1_TX); chk(rv, 8'hC0);
    chk(ep_view, 8'hC0);
    @(posedge ref_clk) host_ack <= 1'b1;
    @(posedge ref_clk) host_ack <= 1'b0;
    rd(ADDR_EP1_TX); chk(rv, 8'h80);
    wr(ADDR_POWER, 8'h0A); #1 chk(resume_drive, 1'b1);
    wr(ADDR_POWER, 8'h08); #1 chk(resume_drive, 1'b0);
    repeat (130) @(posedge ref_clk);
    chk(regulator_ready, 1'b1);
    conclude();
  end
endmodule
